/* include/cou_pkg.sv */
package cou_pkg;
    localparam int          COU_TW         = 16;
    localparam int          COU_NCC        = 5;
    localparam int          COU_NCM        = 8;
    localparam int          COU_NP5        = 8;
    localparam int          COU_NREG       = COU_NCC + COU_NCM;
    localparam logic [15:0] COU_T2_MAX     = 16'hFFFF;
    localparam logic [15:0] COU_CT_MAX     = 16'hFFFF;
    localparam logic [15:0] COU_RST_VALUE  = 16'h0000;
    localparam logic        COU_PIN_RST    = 1'b0;
    localparam logic        COU_MODE0      = 1'b0;
    localparam logic        COU_MODE1      = 1'b1;
    localparam logic        COU_ASSIGN_T2  = 1'b0;
    localparam logic        COU_ASSIGN_CT  = 1'b1;
endpackage

/* hdl/cou_compare_cell.sv */
`timescale 1ns/1ps
`default_nettype none
// one compare register with its port latch pair
module cou_compare_cell
    import cou_pkg::*;
#(
    parameter int W = COU_TW
) (
    input  wire logic         mclk,
    input  wire logic         srst,
    input  wire logic         enable,
    input  wire logic         mode,
    input  wire logic [W-1:0] compareValue,
    input  wire logic [W-1:0] timerCount,
    input  wire logic         timerOverflow,
    input  wire logic         portWrite,
    input  wire logic         portData,
    output logic              match,
    output logic              shadowLatch,
    output logic              pinOut
);
    logic next_shadowLatch;
    logic next_pinOut;

    assign match = enable && (timerCount == compareValue);

    always_comb begin
        next_shadowLatch = shadowLatch;
        next_pinOut      = pinOut;
        if (!enable) begin
            if (portWrite) begin
                next_shadowLatch = portData;
                next_pinOut      = portData;
            end
        end else if (mode == COU_MODE0) begin
            // port writes reach only the shadow latch; match wins so top count leaves a spike
            if (timerOverflow)
                next_pinOut = 1'b0;
            if (match)
                next_pinOut = 1'b1;
            if (portWrite)
                next_shadowLatch = portData;
        end else begin
            if (portWrite)
                next_shadowLatch = portData;
            if (match)
                next_pinOut = portWrite ? portData : shadowLatch;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            shadowLatch <= COU_PIN_RST;
            pinOut      <= COU_PIN_RST;
        end else begin
            shadowLatch <= next_shadowLatch;
            pinOut      <= next_pinOut;
        end
    end

    AST_M0_NOWRITE: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE0 && !match && !timerOverflow |=> $stable(pinOut))
        else $error("mode 0 pin changed without match or overflow");
    AST_M0_RISE: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE0 && match |=> pinOut)
        else $error("mode 0 pin not high after match");
    AST_M0_FALL: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE0 && timerOverflow && !match |=> !pinOut)
        else $error("mode 0 pin not low after overflow");
    AST_M1_HOLD: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE1 && !match |=> $stable(pinOut))
        else $error("mode 1 pin moved without match");
    AST_M1_XFER: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE1 && match && !portWrite |=> pinOut == $past(shadowLatch))
        else $error("mode 1 shadow not transferred");
    AST_M1_TRANSP: assert property (@(posedge mclk) disable iff (srst)
        enable && mode == COU_MODE1 && match && portWrite
        |=> pinOut == shadowLatch && pinOut == $past(portData))
        else $error("mode 1 latches not transparent");
endmodule
`default_nettype wire

/* hdl/cou_compare_output_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module cou_compare_output_unit
    import cou_pkg::*;
#(
    parameter int W   = COU_TW,
    parameter int NCC = COU_NCC,
    parameter int NCM = COU_NCM,
    parameter int NP5 = COU_NP5
) (
    input  wire logic               mclk,
    input  wire logic               srst,
    input  wire logic [W-1:0]       timer2Count,
    input  wire logic               timer2Overflow,
    input  wire logic [W-1:0]       compareTimerCount,
    input  wire logic               compareTimerTick,
    input  wire logic [W-1:0]       compareTimerReload,
    input  wire logic               compareTimerIrqEnable,
    input  wire logic               irqAck,
    input  wire logic [NCC*W-1:0]   ccValues,
    input  wire logic [NCC-1:0]     ccEnable,
    input  wire logic               timer2CompareMode,
    input  wire logic               ccFourthMode,
    input  wire logic               concurrentEnable,
    input  wire logic [NCM*W-1:0]   matchValues,
    input  wire logic [NCM-1:0]     matchEnable,
    input  wire logic [NCM-1:0]     matchAssign,
    input  wire logic [NCC-1:0]     port1Write,
    input  wire logic [NCC-1:0]     port1Data,
    input  wire logic [NCM-1:0]     port4Write,
    input  wire logic [NCM-1:0]     port4Data,
    input  wire logic               port5Write,
    input  wire logic [NP5-1:0]     port5Data,
    input  wire logic               readModifyWrite,
    output logic [NCC-1:0]          port1Pins,
    output logic [NCM-1:0]          port4Pins,
    output logic [NP5-1:0]          port5Pins,
    output logic [NCC-1:0]          port1ReadData,
    output logic [NCM-1:0]          port4ReadData,
    output logic [NP5-1:0]          port5ReadData,
    output logic                    compare_timer_overflow_flag,
    output logic                    compareTimerIrq
);
    logic [NCC-1:0] ccMatch;
    logic [NCC-1:0] ccShadow;
    logic [NCC-1:0] ccMode;
    logic [NCM-1:0] cmMatch;
    logic [NCM-1:0] cmShadow;
    logic [NCM-1:0] cmMode;
    logic [NCM-1:0] cmOverflow;
    logic [NCM-1:0] cmPin;
    logic [NP5-1:0] p5Shadow;
    logic [NP5-1:0] next_p5Shadow;
    logic [NP5-1:0] next_port5Pins;
    logic           ctOverflow;
    logic           next_flag;

    // roll from all ones, qualified by the timer's own count tick
    assign ctOverflow = compareTimerTick && (compareTimerCount == COU_CT_MAX);

    function automatic logic [W-1:0] pick(input logic [NCM*W-1:0] v, input int i);
        pick = v[i*W +: W];
    endfunction

    // 5 timer 2 registers plus 8 match registers
    genvar i;
    generate
        for (i = 0; i < NCC; i++) begin : g_cc
            // register 4 forced to mode 1 with port-5 lines; others from mode bit
            assign ccMode[i] = (i == NCC - 1) ? (ccFourthMode | concurrentEnable)
                                              : timer2CompareMode;
            cou_compare_cell #(.W(W)) u_cell (
                .mclk         (mclk),
                .srst         (srst),
                .enable       (ccEnable[i]),
                .mode         (ccMode[i]),
                .compareValue (ccValues[i*W +: W]),
                .timerCount   (timer2Count),
                .timerOverflow(timer2Overflow),
                .portWrite    (port1Write[i]),
                .portData     (port1Data[i]),
                .match        (ccMatch[i]),
                .shadowLatch  (ccShadow[i]),
                .pinOut       (port1Pins[i])
            );
        end
        for (i = 0; i < NCM; i++) begin : g_cm
            // mode tied to timer assignment, never software choice
            assign cmMode[i] = (matchAssign[i] == COU_ASSIGN_T2) ? COU_MODE1
                                                                 : COU_MODE0;
            assign cmOverflow[i] = (matchAssign[i] == COU_ASSIGN_CT) ? ctOverflow
                                                                     : timer2Overflow;
            cou_compare_cell #(.W(W)) u_cell (
                .mclk         (mclk),
                .srst         (srst),
                .enable       (matchEnable[i]),
                .mode         (cmMode[i]),
                .compareValue (pick(matchValues, i)),
                .timerCount   ((matchAssign[i] == COU_ASSIGN_CT) ? compareTimerCount
                                                                 : timer2Count),
                .timerOverflow(cmOverflow[i]),
                .portWrite    (port4Write[i]),
                .portData     (port4Data[i]),
                .match        (cmMatch[i]),
                .shadowLatch  (cmShadow[i]),
                .pinOut       (cmPin[i])
            );
        end
    endgenerate

    assign port4Pins = cmPin;

    // port 5 driven by the fourth register's match while concurrent compare is on
    always_comb begin
        next_p5Shadow  = p5Shadow;
        next_port5Pins = port5Pins;
        if (port5Write)
            next_p5Shadow = port5Data;
        if (concurrentEnable && ccMatch[NCC-1])
            next_port5Pins = port5Write ? port5Data : p5Shadow;
        else if (!concurrentEnable && port5Write)
            next_port5Pins = port5Data;
    end

    // flag lives one cycle and is cleared by hardware at the next edge
    always_comb begin
        next_flag = ctOverflow;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            p5Shadow                    <= {NP5{COU_PIN_RST}};
            port5Pins                   <= {NP5{COU_PIN_RST}};
            compare_timer_overflow_flag <= 1'b0;
        end else begin
            p5Shadow                    <= next_p5Shadow;
            port5Pins                   <= next_port5Pins;
            compare_timer_overflow_flag <= next_flag;
        end
    end

    assign compareTimerIrq = compare_timer_overflow_flag & compareTimerIrqEnable;

    // mode 1 lines give shadow to read-modify-write, pin otherwise
    always_comb begin
        for (int k = 0; k < NCC; k++)
            port1ReadData[k] = (readModifyWrite && ccMode[k]) ? ccShadow[k]
                                                               : port1Pins[k];
        for (int k = 0; k < NCM; k++)
            port4ReadData[k] = (readModifyWrite && cmMode[k]) ? cmShadow[k]
                                                               : cmPin[k];
        port5ReadData = (readModifyWrite && concurrentEnable) ? p5Shadow : port5Pins;
    end

    AST_CTF_SET: assert property (@(posedge mclk) disable iff (srst)
        compareTimerTick && compareTimerCount == COU_CT_MAX |=> compare_timer_overflow_flag)
        else $error("overflow flag not set");
    AST_CTF_CLR: assert property (@(posedge mclk) disable iff (srst)
        compare_timer_overflow_flag && !ctOverflow |=> !compare_timer_overflow_flag)
        else $error("overflow flag not cleared by hardware");
    AST_IRQ: assert property (@(posedge mclk) disable iff (srst)
        compareTimerIrq |-> compare_timer_overflow_flag && compareTimerIrqEnable)
        else $error("irq without flag");
    AST_RMW: assert property (@(posedge mclk) disable iff (srst)
        readModifyWrite && ccMode[0] |-> port1ReadData[0] == ccShadow[0])
        else $error("rmw read not from shadow");
    AST_P5_HOLD: assert property (@(posedge mclk) disable iff (srst)
        concurrentEnable && !ccMatch[NCC-1] |=> $stable(port5Pins))
        else $error("port 5 moved without match");

    // irq is tied to the roll itself, not only to the flag
    AST_IRQ_SRC: assert property (@(posedge mclk) disable iff (srst)
        compareTimerTick && compareTimerCount == COU_CT_MAX ##1 compareTimerIrqEnable
        |-> compareTimerIrq)
        else $error("no irq after compare timer roll");
    AST_CTF_ONLY: assert property (@(posedge mclk) disable iff (srst)
        !(compareTimerTick && compareTimerCount == COU_CT_MAX)
        |=> !compare_timer_overflow_flag)
        else $error("overflow flag without roll");
    // register 0 and match register 0 stand for their siblings
    AST_T2_SPIKE: assert property (@(posedge mclk) disable iff (srst)
        ccEnable[0] && ccMode[0] == COU_MODE0 && ccMatch[0] && timer2Overflow
        |=> port1Pins[0])
        else $error("timer 2 spike lost when match meets overflow");
    AST_CT_FALL: assert property (@(posedge mclk) disable iff (srst)
        matchEnable[0] && matchAssign[0] == COU_ASSIGN_CT && ctOverflow && !cmMatch[0]
        |=> !port4Pins[0])
        else $error("compare timer output not low after roll");
    AST_CM_T2_HOLD: assert property (@(posedge mclk) disable iff (srst)
        matchEnable[0] && matchAssign[0] == COU_ASSIGN_T2 && !cmMatch[0]
        |=> $stable(port4Pins[0]))
        else $error("timer 2 match output moved without match");
    AST_CM_T2_XFER: assert property (@(posedge mclk) disable iff (srst)
        matchEnable[0] && matchAssign[0] == COU_ASSIGN_T2 && cmMatch[0] && !port4Write[0]
        |=> port4Pins[0] == $past(cmShadow[0]))
        else $error("timer 2 match output missed its shadow");

    // port 5 pattern follows the same shadow rules as a single mode 1 line
    AST_P5_XFER: assert property (@(posedge mclk) disable iff (srst)
        concurrentEnable && ccMatch[NCC-1] && !port5Write |=> port5Pins == $past(p5Shadow))
        else $error("port 5 pattern not transferred");
    AST_P5_TRANSP: assert property (@(posedge mclk) disable iff (srst)
        concurrentEnable && ccMatch[NCC-1] && port5Write
        |=> port5Pins == $past(port5Data) && p5Shadow == port5Pins)
        else $error("port 5 latches not transparent");
    AST_READ_PIN: assert property (@(posedge mclk) disable iff (srst)
        !readModifyWrite |-> port1ReadData == port1Pins && port4ReadData == port4Pins
        && port5ReadData == port5Pins)
        else $error("plain port read not from pins");
endmodule
`default_nettype wire

/* tb/compare_output_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module compare_output_unit_tb_top
    import cou_pkg::*;
;
    logic                     mclk, srst, t2Ovf, ctTick, irqEn, irqAck;
    logic                     t2Mode, fourthMode, concEn, p5Write, rmw, flag, irq;
    logic [COU_TW-1:0]        t2Count, ctCount, ctReload, v, w, d;
    logic [COU_NCC*COU_TW-1:0] ccValues;
    logic [COU_NCM*COU_TW-1:0] matchValues;
    logic [COU_NCC-1:0]       ccEnable, p1Write, p1Data, p1Pins, p1Rd;
    logic [COU_NCM-1:0]       matchEnable, matchAssign, p4Write, p4Data, p4Pins, p4Rd;
    logic [COU_NP5-1:0]       p5Data, p5Pins, p5Rd;
    int                       mismatches, comparisons, seed;

    cou_compare_output_unit dut (
        .mclk(mclk), .srst(srst), .timer2Count(t2Count), .timer2Overflow(t2Ovf),
        .compareTimerCount(ctCount), .compareTimerTick(ctTick),
        .compareTimerReload(ctReload), .compareTimerIrqEnable(irqEn), .irqAck(irqAck),
        .ccValues(ccValues), .ccEnable(ccEnable), .timer2CompareMode(t2Mode),
        .ccFourthMode(fourthMode), .concurrentEnable(concEn), .matchValues(matchValues),
        .matchEnable(matchEnable), .matchAssign(matchAssign), .port1Write(p1Write),
        .port1Data(p1Data), .port4Write(p4Write), .port4Data(p4Data), .port5Write(p5Write),
        .port5Data(p5Data), .readModifyWrite(rmw), .port1Pins(p1Pins), .port4Pins(p4Pins),
        .port5Pins(p5Pins), .port1ReadData(p1Rd), .port4ReadData(p4Rd),
        .port5ReadData(p5Rd), .compare_timer_overflow_flag(flag), .compareTimerIrq(irq)
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chkVec(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkBit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cyc();
        @(negedge mclk);
    endtask

    task automatic report_and_stop();
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        {t2Ovf, ctTick, irqEn, irqAck, t2Mode, fourthMode, concEn, p5Write, rmw} = '0;
        {t2Count, ctCount, ctReload, ccValues, matchValues} = '0;
        {ccEnable, p1Write, p1Data, matchEnable, matchAssign, p4Write, p4Data, p5Data} = '0;
        srst = 1'b1;
        seed = 1;
        for (int r = 0; r < 6; r++) begin
            // corner values first, then random ones
            v = (r == 0) ? 16'h0000 : (r == 1) ? 16'hFFFF : COU_TW'($random(seed));
            w = v ^ 16'h8000;
            d = COU_TW'($random(seed));
            ctReload = COU_TW'($random(seed));
            irqAck = d[3];
            srst = 1'b1;
            repeat (8) cyc();
            srst = 1'b0;
            chkVec("reset pins", 8'h00, {3'b000, p1Pins} | p4Pins | p5Pins);
            chkBit("reset flag", 1'b0, flag);
            ccValues = {COU_NCC{v}};
            matchValues = {COU_NCM{w}};
            {ccEnable, matchEnable, matchAssign} = '1;
            {t2Mode, fourthMode, concEn} = 3'b000;
            t2Count = v + 16'h0001;
            ctCount = v;
            irqEn = r[0];
            p1Write = 5'h1F;
            p1Data = 5'h1F;
            cyc();
            p1Write = 5'h00;
            cyc();
            chkVec("mode0 write ignored", 8'h00, {3'b000, p1Pins});
            t2Count = v;
            cyc();
            chkVec("mode0 rise", 8'h1F, {3'b000, p1Pins});
            t2Count = v + 16'h0002;
            t2Ovf = 1'b1;
            cyc();
            chkVec("mode0 fall", 8'h00, {3'b000, p1Pins});
            t2Count = v;
            cyc();
            t2Ovf = 1'b0;
            chkVec("match over overflow", 8'h1F, {3'b000, p1Pins});
            t2Count = v + 16'h0001;
            ctCount = w;
            cyc();
            chkVec("ct mode0 rise", 8'hFF, p4Pins);
            ctCount = 16'hFFFF;
            ctTick = 1'b1;
            cyc();
            ctTick = 1'b0;
            ctCount = ctReload;
            chkBit("flag set", 1'b1, flag);
            chkBit("irq", irqEn, irq);
            chkVec("ct end spike", (w == 16'hFFFF) ? 8'hFF : 8'h00, p4Pins);
            cyc();
            chkBit("flag clear", 1'b0, flag);
            chkBit("irq clear", 1'b0, irq);
            // registers 0 to 4 into mode 1, match registers onto timer 2
            {t2Mode, fourthMode} = 2'b11;
            matchAssign = '0;
            {p1Write, p4Write} = '1;
            p1Data = d[4:0];
            p4Data = d[15:8];
            cyc();
            {p1Write, p4Write} = '0;
            cyc();
            chkVec("mode1 held", 8'h1F, {3'b000, p1Pins});
            rmw = 1'b1;
            cyc();
            chkVec("rmw shadow p1", {3'b000, d[4:0]}, {3'b000, p1Rd});
            chkVec("rmw shadow p4", d[15:8], p4Rd);
            rmw = 1'b0;
            cyc();
            chkVec("plain read pin", 8'h1F, {3'b000, p1Rd});
            t2Count = v;
            cyc();
            chkVec("mode1 transfer", {3'b000, d[4:0]}, {3'b000, p1Pins});
            p1Write = 5'h1F;
            p1Data = ~d[4:0];
            cyc();
            p1Write = 5'h00;
            chkVec("transparent", {3'b000, ~d[4:0]}, {3'b000, p1Pins});
            t2Count = w;
            cyc();
            chkVec("match reg mode1", d[15:8], p4Pins);
            concEn = 1'b1;
            p5Write = 1'b1;
            p5Data = d[7:0] ^ 8'hA5;
            t2Count = v + 16'h0001;
            cyc();
            p5Write = 1'b0;
            rmw = 1'b1;
            cyc();
            chkVec("rmw shadow p5", d[7:0] ^ 8'hA5, p5Rd);
            chkVec("port5 held", 8'h00, p5Pins);
            rmw = 1'b0;
            t2Count = v;
            cyc();
            chkVec("concurrent port5", d[7:0] ^ 8'hA5, p5Pins);
            p5Write = 1'b1;
            p5Data = ~(d[7:0] ^ 8'hA5);
            cyc();
            p5Write = 1'b0;
            chkVec("port5 transparent", ~(d[7:0] ^ 8'hA5), p5Pins);
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
